// file: rtl/dica_pkg.sv
`default_nettype none

package dica_pkg;

	// ****************************************
	// Register addresses.
	// ****************************************
	localparam logic [6:0] ADDR_INCHK = 7'h01;
	localparam logic [6:0] ADDR_PATH = 7'h02;
	localparam logic [6:0] ADDR_FSTX = 7'h03;
	localparam logic [6:0] ADDR_RESULTS = 7'h04;
	localparam logic [6:0] ADDR_ALARM = 7'h05;
	localparam logic [6:0] ADDR_TEMP = 7'h06;
	localparam logic [6:0] ADDR_MASK = 7'h07;
	localparam logic [6:0] ADDR_PAT0 = 7'h25;
	localparam logic [6:0] N_PATTERNS = 7'h08;

	// ****************************************
	// Reset values and writable bits.
	// ****************************************
	localparam logic [15:0] RST_INCHK = 16'h040E;
	localparam logic [15:0] RST_PATH = 16'h7000;
	localparam logic [15:0] RST_FSTX = 16'hF000;
	localparam logic [15:0] RST_MASK = 16'hFFFF;
	localparam logic [15:0] WMASK_INCHK = 16'h9FFE;
	localparam logic [15:0] WMASK_PATH = 16'h70FA;
	localparam logic [15:0] WMASK_FSTX = 16'hF001;
	localparam logic [7:0][15:0] PAT_RST = {16'hC6C6, 16'hAAAA, 16'h1616, 16'h1A1A,
		16'h4545, 16'hEAEA, 16'hB6B6, 16'h7A7A};

	// ****************************************
	// Field positions of the input check control register.
	// ****************************************
	localparam int B_IOTEST = 15;
	localparam int B_AUTOCLR = 12;
	localparam int B_ODD = 11;
	localparam int B_PAR_EN = 10;
	localparam int B_DUAL = 9;
	localparam int B_REVIF = 8;
	localparam int B_INV_A = 7;
	localparam int B_EN_NEAR2 = 3;
	localparam int B_EN_NEAR1 = 2;
	localparam int B_EN_COLL = 1;

	// ****************************************
	// Field positions of the path and shutdown control register.
	// ****************************************
	localparam int B_SD_DACCLK = 14;
	localparam int B_SD_DATACLK = 13;
	localparam int B_SD_COLL = 12;
	localparam int B_FOURW = 7;
	localparam int B_MIX = 6;
	localparam int B_BOOST = 5;
	localparam int B_OSC = 4;
	localparam int B_REVBUS = 3;
	localparam int B_TWOS = 1;

	// ****************************************
	// Full-scale, transmit and temperature fields.
	// ****************************************
	localparam int FS_MSB = 15;
	localparam int FS_LSB = 12;
	localparam int B_TXEN = 0;
	localparam int TEMP_LSB = 8;

	// ****************************************
	// Alarm status bit positions.
	// ****************************************
	localparam int A_ZERO = 15;
	localparam int A_COLL = 13;
	localparam int A_NEAR1 = 12;
	localparam int A_NEAR2 = 11;
	localparam int A_DACCLK = 10;
	localparam int A_DATACLK = 9;
	localparam int A_OFF = 8;
	localparam int A_IOTEST = 7;
	localparam int A_PLL = 5;
	localparam int A_PAR_A = 4;

	// ****************************************
	// Counts and codes.
	// ****************************************
	localparam logic [6:0] AUTOCLR_COUNT = 7'h40;
	localparam logic [15:0] MIDSCALE = 16'h8000;
	localparam logic [4:0] INSTR_BITS = 5'h08;
	localparam logic [4:0] DATA_BITS = 5'h10;

	typedef enum logic [1:0] {
		SER_IDLE = 2'b00,
		SER_INSTR = 2'b01,
		SER_DATA = 2'b10,
		SER_DONE = 2'b11
	} dica_ser_t;

endpackage

`default_nettype wire

// file: rtl/dica_regs.sv
// Function
// - Pattern check runs, outputs forced off.
// - Alarms auto-clear after 64 good samples.
// - Parity sense bit: zero even, one odd.
// - Parity enable checks each word against pin.
// - Dual or single parity, needs enable.
// - Interface reversal rotates strobe, sync, parity pins.
// - Per-channel invert complements channel output data.
// - FIFO nearness and collision alarms individually enabled.
// - Clock-loss alarms shut outputs when enabled.
// - Collision alarm shuts outputs when enabled.
// - Serial width bit picks four or three wire.
// - Mixer enable and six dB boost bit.
// - Oscillator enable bit drives oscillator on.
// - Bus reversal swaps input bit order.
// - Format bit selects two's complement or offset.
// - Full-scale field scales current, resets all ones.
// - Transmit on when register bit or pin.
// - Pattern results mark failing bit positions, write-clear.
// - Zero write pointer raises an alarm.
// - FIFO alarm field encodes nearness and collision.
// - Output-off alarm forces every channel to mid-scale when its cause's shutdown bit is set.
// - Pattern mismatch alarm set on differing data.
`default_nettype none

module dica_regs
	import dica_pkg::*;
(
	input wire logic CLK,
	input wire logic NRST,
	input wire logic SCLK,
	input wire logic SDENB_N,
	input wire logic SDIO_IN,
	output logic SDIO_OUT,
	output logic SDIO_OE_N,
	output logic SDO_OUT,
	output logic SDO_OE_N,
	input wire logic [15:0] BUS_AB,
	input wire logic [15:0] BUS_CD,
	input wire logic INPUT_STROBE,
	input wire logic SYNC_INPUT,
	input wire logic CHECK_BIT_INPUT,
	input wire logic TRANSMIT_ENABLE_PIN,
	input wire logic [7:0] FIFO_WR_PTR,
	input wire logic [7:0] FIFO_RD_PTR,
	input wire logic DACCLK_LOST,
	input wire logic DATACLK_LOST,
	input wire logic PLL_UNLOCK,
	input wire logic [7:0] TEMP_CODE,
	output logic [15:0] OUT_A,
	output logic [15:0] OUT_B,
	output logic [15:0] OUT_C,
	output logic [15:0] OUT_D,
	output logic [4:0] OUT_FULLSCALE,
	output logic OUTPUT_OFF,
	output logic MIXER_ON,
	output logic MIXER_BOOST,
	output logic OSC_ON,
	output logic SERIAL_FOUR_WIRE,
	output logic FIFO_SYNC,
	output logic ALARM
);

	// ****************************************
	// State.
	// ****************************************
	typedef struct packed {
		logic [15:0] inchk;
		logic [15:0] path;
		logic [15:0] fstx;
		logic [15:0] mask;
		logic [15:0] results;
		logic [15:0] alarms;
		logic [7:0][15:0] pat;
		logic [6:0] good_cnt;
		logic [1:0] word;
		logic [2:0] pat_idx;
		logic strobe_q;
		logic sclk_q;
		dica_ser_t ser;
		logic [4:0] bit_cnt;
		logic [7:0] instr;
		logic [15:0] shreg;
		logic [15:0] out_a;
		logic [15:0] out_b;
		logic [15:0] out_c;
		logic [15:0] out_d;
		logic [4:0] fullscale;
		logic output_off;
		logic mixer_on;
		logic mixer_boost;
		logic osc_on;
		logic four_wire;
		logic fifo_sync;
		logic alarm;
		logic sdio_out;
		logic sdio_oe_n;
		logic sdo_out;
		logic sdo_oe_n;
	} dica_state_t;

	localparam dica_state_t RST_ST = '{
		inchk: RST_INCHK,
		path: RST_PATH,
		fstx: RST_FSTX,
		mask: RST_MASK,
		pat: PAT_RST,
		ser: SER_IDLE,
		out_a: MIDSCALE,
		out_b: MIDSCALE,
		out_c: MIDSCALE,
		out_d: MIDSCALE,
		fullscale: {1'b0, RST_FSTX[FS_MSB:FS_LSB]} + 5'h01,
		output_off: 1'b1,
		sdio_oe_n: 1'b1,
		sdo_oe_n: 1'b1,
		default: '0
	};

	dica_state_t r_ff;
	dica_state_t nxt_r;

	// ****************************************
	// Helper functions.
	// ****************************************

	// Reverses the bit order of one input word.
	function automatic logic [15:0] bit_rev(input logic [15:0] v);
		logic [15:0] o;
		o = '0;
		for (int i = 0; i < 16; i++) begin
			o[i] = v[15 - i];
		end
		return o;
	endfunction

	// Rotates a one-hot pointer left by n places.
	function automatic logic [7:0] rot(input logic [7:0] v, input int n);
		return 8'((v << n) | (v >> (8 - n)));
	endfunction

	// Converts one sample to offset binary and applies the channel invert.
	function automatic logic [15:0] conv(input logic [15:0] d, input logic twos, input logic inv);
		logic [15:0] o;
		o = twos ? {~d[15], d[14:0]} : d;
		return inv ? ~o : o;
	endfunction

	// ****************************************
	// Input pin mapping and data conditioning.
	// ****************************************
	logic strobe;
	logic sync;
	logic chk;
	logic [15:0] ab;
	logic [15:0] cd;
	logic new_frame;
	logic [1:0] word;
	logic [2:0] pat_idx;

	// Rotation of the auxiliary inputs when the interface is reversed.
	assign strobe = r_ff.inchk[B_REVIF] ? SYNC_INPUT : INPUT_STROBE;
	assign sync = r_ff.inchk[B_REVIF] ? CHECK_BIT_INPUT : SYNC_INPUT;
	assign chk = r_ff.inchk[B_REVIF] ? INPUT_STROBE : CHECK_BIT_INPUT;
	assign ab = r_ff.path[B_REVBUS] ? bit_rev(BUS_AB) : BUS_AB;
	assign cd = r_ff.path[B_REVBUS] ? bit_rev(BUS_CD) : BUS_CD;

	// A strobe rising edge restarts word and pattern sequencing.
	assign new_frame = strobe & ~r_ff.strobe_q;
	assign word = new_frame ? 2'b00 : r_ff.word;
	assign pat_idx = new_frame ? 3'b000 : r_ff.pat_idx;

	// ****************************************
	// Checkers.
	// ****************************************
	logic [15:0] pdata_dual;
	logic par_bad;
	logic [15:0] mism;
	logic coll;
	logic near1;
	logic near2;
	logic [15:0] set;
	logic good;

	// Dual mode checks one half-bus per word, single mode the whole 32 bits.
	assign pdata_dual = word[0] ? cd : ab;
	assign par_bad = r_ff.inchk[B_PAR_EN] & (chk ^ r_ff.inchk[B_ODD] ^
		(r_ff.inchk[B_DUAL] ? ^pdata_dual : ^{ab, cd}));

	// Pattern checker compares both buses against the current pattern word.
	assign mism = r_ff.inchk[B_IOTEST] ?
		((ab ^ r_ff.pat[pat_idx]) | (cd ^ r_ff.pat[pat_idx])) : 16'h0000;

	// FIFO pointer distance from the one-hot write and read pointers.
	assign coll = (FIFO_WR_PTR == FIFO_RD_PTR);
	assign near1 = (FIFO_WR_PTR == rot(FIFO_RD_PTR, 1)) | (FIFO_RD_PTR == rot(FIFO_WR_PTR, 1));
	assign near2 = (FIFO_WR_PTR == rot(FIFO_RD_PTR, 2)) | (FIFO_RD_PTR == rot(FIFO_WR_PTR, 2));

	// Alarm events raised in this cycle.
	always_comb begin
		set = '0;
		set[A_ZERO] = (FIFO_WR_PTR == 8'h00);
		set[A_COLL] = coll & r_ff.inchk[B_EN_COLL];
		set[A_NEAR1] = near1 & r_ff.inchk[B_EN_NEAR1];
		set[A_NEAR2] = near2 & r_ff.inchk[B_EN_NEAR2];
		set[A_DACCLK] = DACCLK_LOST;
		set[A_DATACLK] = DATACLK_LOST;
		set[A_OFF] = set[A_COLL] | DACCLK_LOST | DATACLK_LOST;
		set[A_IOTEST] = |mism;
		set[A_PLL] = PLL_UNLOCK;
		if (par_bad) begin
			if (r_ff.inchk[B_DUAL]) begin
				set[A_PAR_A - int'(word)] = 1'b1;
			end else begin
				set[A_PAR_A - int'(word[0])] = 1'b1;
			end
		end
	end

	assign good = ~par_bad & ~(|mism);

	// ****************************************
	// Serial access port signals.
	// ****************************************
	logic rise;
	logic fall;
	logic [6:0] raddr;
	logic [15:0] rdata;
	logic wr_en;
	logic [6:0] wr_addr;
	logic [15:0] wr_data;
	logic clr_alarm;
	logic clr_results;
	logic autoclr;
	logic shut;
	logic [15:0] drv;
	logic [15:0] drv_b;

	assign rise = SCLK & ~r_ff.sclk_q;
	assign fall = ~SCLK & r_ff.sclk_q;
	assign raddr = {r_ff.instr[5:0], SDIO_IN};

	// Read data selection; unmapped addresses read zero.
	always_comb begin
		rdata = 16'h0000;
		if (raddr == ADDR_INCHK) begin
			rdata = r_ff.inchk;
		end else if (raddr == ADDR_PATH) begin
			rdata = r_ff.path;
		end else if (raddr == ADDR_FSTX) begin
			rdata = r_ff.fstx;
		end else if (raddr == ADDR_RESULTS) begin
			rdata = r_ff.results;
		end else if (raddr == ADDR_ALARM) begin
			rdata = r_ff.alarms;
		end else if (raddr == ADDR_TEMP) begin
			rdata = {TEMP_CODE, 8'h00};
		end else if (raddr == ADDR_MASK) begin
			rdata = r_ff.mask;
		end else if (raddr >= ADDR_PAT0 && raddr < ADDR_PAT0 + N_PATTERNS) begin
			rdata = r_ff.pat[3'(raddr - ADDR_PAT0)];
		end
	end

	// ****************************************
	// Next-state logic.
	// ****************************************
	always_comb begin
		nxt_r = r_ff;
		wr_en = 1'b0;
		wr_addr = r_ff.instr[6:0];
		wr_data = {r_ff.shreg[14:0], SDIO_IN};
		nxt_r.sclk_q = SCLK;
		nxt_r.strobe_q = strobe;
		nxt_r.word = word + 2'b01;
		nxt_r.pat_idx = pat_idx + 3'b001;
		nxt_r.fifo_sync = sync;

		// Serial access: instruction byte, then sixteen data bits.
		if (SDENB_N) begin
			nxt_r.ser = SER_IDLE;
			nxt_r.bit_cnt = '0;
			nxt_r.sdio_oe_n = 1'b1;
			nxt_r.sdo_oe_n = 1'b1;
		end else begin
			case (r_ff.ser)
				SER_IDLE, SER_INSTR: begin
					if (rise) begin
						nxt_r.instr = {r_ff.instr[6:0], SDIO_IN};
						nxt_r.bit_cnt = r_ff.bit_cnt + 5'h01;
						nxt_r.ser = SER_INSTR;
						if (r_ff.bit_cnt == INSTR_BITS - 5'h01) begin
							nxt_r.ser = SER_DATA;
							nxt_r.bit_cnt = '0;
							if (r_ff.instr[6]) begin
								nxt_r.shreg = rdata;
								nxt_r.sdo_out = rdata[15];
								nxt_r.sdio_out = rdata[15];
								nxt_r.sdo_oe_n = ~r_ff.path[B_FOURW];
								nxt_r.sdio_oe_n = r_ff.path[B_FOURW];
							end
						end
					end
				end
				SER_DATA: begin
					if (rise) begin
						nxt_r.bit_cnt = r_ff.bit_cnt + 5'h01;
						if (!r_ff.instr[7]) begin
							nxt_r.shreg = wr_data;
						end
						if (r_ff.bit_cnt == DATA_BITS - 5'h01) begin
							nxt_r.ser = SER_DONE;
							wr_en = ~r_ff.instr[7];
						end
					end else if (fall && r_ff.instr[7]) begin
						nxt_r.shreg = {r_ff.shreg[14:0], 1'b0};
						nxt_r.sdo_out = r_ff.shreg[14];
						nxt_r.sdio_out = r_ff.shreg[14];
					end
				end
				default: begin
					// Drive low after the final falling edge until deselected.
					if (fall) begin
						nxt_r.sdo_out = 1'b0;
						nxt_r.sdio_out = 1'b0;
					end
				end
			endcase
		end

		// Register writes.
		clr_alarm = 1'b0;
		clr_results = 1'b0;
		if (wr_en) begin
			if (wr_addr == ADDR_INCHK) begin
				nxt_r.inchk = wr_data & WMASK_INCHK;
			end else if (wr_addr == ADDR_PATH) begin
				nxt_r.path = wr_data & WMASK_PATH;
			end else if (wr_addr == ADDR_FSTX) begin
				nxt_r.fstx = wr_data & WMASK_FSTX;
			end else if (wr_addr == ADDR_RESULTS) begin
				clr_results = 1'b1;
			end else if (wr_addr == ADDR_ALARM) begin
				clr_alarm = 1'b1;
			end else if (wr_addr == ADDR_MASK) begin
				nxt_r.mask = wr_data;
			end else if (wr_addr >= ADDR_PAT0 && wr_addr < ADDR_PAT0 + N_PATTERNS) begin
				nxt_r.pat[3'(wr_addr - ADDR_PAT0)] = wr_data;
			end
		end

		// Good-sample run counter for automatic alarm clearing.
		autoclr = 1'b0;
		if (!good) begin
			nxt_r.good_cnt = '0;
		end else if (r_ff.good_cnt == AUTOCLR_COUNT - 7'h01) begin
			nxt_r.good_cnt = '0;
			autoclr = r_ff.inchk[B_AUTOCLR];
		end else begin
			nxt_r.good_cnt = r_ff.good_cnt + 7'h01;
		end

		// Sticky flags; a new event wins over a clear in the same cycle.
		nxt_r.alarms = (r_ff.alarms & ~{16{clr_alarm | autoclr}}) | set;
		nxt_r.results = (r_ff.results & ~{16{clr_results | autoclr}}) | mism;

		// Output shutdown from enabled loss and collision alarms.
		shut = (r_ff.alarms[A_DACCLK] & r_ff.path[B_SD_DACCLK]) |
			(r_ff.alarms[A_DATACLK] & r_ff.path[B_SD_DATACLK]) |
			(r_ff.alarms[A_COLL] & r_ff.path[B_SD_COLL]);
		nxt_r.output_off = (shut & r_ff.alarms[A_OFF]) | r_ff.inchk[B_IOTEST] |
			~(r_ff.fstx[B_TXEN] | TRANSMIT_ENABLE_PIN);

		// Channel samples: A and C on even words, B and D on odd words.
		drv = conv(ab, r_ff.path[B_TWOS], r_ff.inchk[word[0] ? B_INV_A - 1 : B_INV_A]);
		drv_b = conv(cd, r_ff.path[B_TWOS], r_ff.inchk[word[0] ? B_INV_A - 3 : B_INV_A - 2]);
		if (nxt_r.output_off) begin
			nxt_r.out_a = MIDSCALE;
			nxt_r.out_b = MIDSCALE;
			nxt_r.out_c = MIDSCALE;
			nxt_r.out_d = MIDSCALE;
		end else if (!word[0]) begin
			nxt_r.out_a = drv;
			nxt_r.out_c = drv_b;
		end else begin
			nxt_r.out_b = drv;
			nxt_r.out_d = drv_b;
		end

		// Configuration outputs.
		nxt_r.fullscale = {1'b0, r_ff.fstx[FS_MSB:FS_LSB]} + 5'h01;
		nxt_r.mixer_on = r_ff.path[B_MIX];
		nxt_r.mixer_boost = r_ff.path[B_BOOST];
		nxt_r.osc_on = r_ff.path[B_OSC];
		nxt_r.four_wire = r_ff.path[B_FOURW];
		nxt_r.alarm = |(r_ff.alarms & ~r_ff.mask);
	end

	// ****************************************
	// State register.
	// ****************************************
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			r_ff <= RST_ST;
		end else begin
			r_ff <= nxt_r;
		end
	end

	// Outputs straight from the state register.
	assign SDIO_OUT = r_ff.sdio_out;
	assign SDIO_OE_N = r_ff.sdio_oe_n;
	assign SDO_OUT = r_ff.sdo_out;
	assign SDO_OE_N = r_ff.sdo_oe_n;
	assign OUT_A = r_ff.out_a;
	assign OUT_B = r_ff.out_b;
	assign OUT_C = r_ff.out_c;
	assign OUT_D = r_ff.out_d;
	assign OUT_FULLSCALE = r_ff.fullscale;
	assign OUTPUT_OFF = r_ff.output_off;
	assign MIXER_ON = r_ff.mixer_on;
	assign MIXER_BOOST = r_ff.mixer_boost;
	assign OSC_ON = r_ff.osc_on;
	assign SERIAL_FOUR_WIRE = r_ff.four_wire;
	assign FIFO_SYNC = r_ff.fifo_sync;
	assign ALARM = r_ff.alarm;

endmodule

`default_nettype wire

// file: bench/dica_regs_checker.sv
`default_nettype none

module dica_regs_checker
	import dica_pkg::*;
(
	input wire logic CLK,
	input wire logic NRST,
	input wire logic SDENB_N,
	input wire logic SDIO_OE_N,
	input wire logic SDO_OE_N,
	input wire logic SYNC_INPUT,
	input wire logic CHECK_BIT_INPUT,
	input wire logic DACCLK_LOST,
	input wire logic DATACLK_LOST,
	input wire logic [15:0] OUT_A,
	input wire logic [15:0] OUT_B,
	input wire logic [15:0] OUT_C,
	input wire logic [15:0] OUT_D,
	input wire logic [4:0] OUT_FULLSCALE,
	input wire logic OUTPUT_OFF,
	input wire logic FIFO_SYNC,
	input wire logic ALARM
);
	timeunit 1ns;
	timeprecision 1ps;

	// ****************************************
	// Port properties, one clock domain.
	// ****************************************
	default clocking @(posedge CLK);
	endclocking
	default disable iff (!NRST);

	// Forced-off outputs all sit at mid-scale.
	property p_off_mid;
		OUTPUT_OFF |-> {OUT_A, OUT_B, OUT_C, OUT_D} == {4{MIDSCALE}};
	endproperty
	a_off_mid: assert property (p_off_mid) else $error("channel not at mid-scale while off");

	// Full-scale code stays between one and sixteen steps.
	property p_fs_range;
		OUT_FULLSCALE inside {[5'h01:5'h10]};
	endproperty
	a_fs_range: assert property (p_fs_range) else $error("full-scale step count out of range");

	// A lost converter clock shuts the outputs within three cycles.
	property p_dacclk_off;
		$rose(DACCLK_LOST) |-> ##[1:3] OUTPUT_OFF;
	endproperty
	a_dacclk_off: assert property (p_dacclk_off) else $error("converter clock loss left outputs on");

	// A lost data clock shuts the outputs within three cycles.
	property p_dataclk_off;
		$rose(DATACLK_LOST) |-> ##[1:3] OUTPUT_OFF;
	endproperty
	a_dataclk_off: assert property (p_dataclk_off) else $error("data clock loss left outputs on");

	// Serial data pins are released while the port is deselected.
	property p_oe_idle;
		SDENB_N && $past(SDENB_N) |-> SDIO_OE_N && SDO_OE_N;
	endproperty
	a_oe_idle: assert property (p_oe_idle) else $error("serial pin driven while deselected");

	// Only one of the two serial pins carries read data.
	property p_oe_one;
		SDIO_OE_N || SDO_OE_N;
	endproperty
	a_oe_one: assert property (p_oe_one) else $error("both serial pins driven");

	// With auto-clear off, the alarm pin only drops after a serial frame.
	property p_sticky;
		SDENB_N && $past(SDENB_N) && $past(SDENB_N, 2) && $past(SDENB_N, 3) |-> !$fell(ALARM);
	endproperty
	a_sticky: assert property (p_sticky) else $error("alarm dropped with no serial write");

	// The sync seen by the FIFO is one of the two candidate pins.
	property p_fifo_sync;
		$past(NRST) |-> FIFO_SYNC == $past(SYNC_INPUT) || FIFO_SYNC == $past(CHECK_BIT_INPUT);
	endproperty
	a_fifo_sync: assert property (p_fifo_sync) else $error("fifo sync not taken from a sync pin");

endmodule

bind dica_regs dica_regs_checker dica_regs_checker_inst (.CLK, .NRST, .SDENB_N, .SDIO_OE_N, .SDO_OE_N,
	.SYNC_INPUT, .CHECK_BIT_INPUT, .DACCLK_LOST, .DATACLK_LOST, .OUT_A, .OUT_B, .OUT_C, .OUT_D,
	.OUT_FULLSCALE, .OUTPUT_OFF, .FIFO_SYNC, .ALARM);

`default_nettype wire

// file: bench/dica_host.sv
`default_nettype none

module dica_host (
	input wire logic clk,
	input wire logic rd_line,
	output logic sclk,
	output logic sdenb_n,
	output logic sd
);
	timeunit 1ns;
	timeprecision 1ps;

	// Half period of the serial clock in system cycles.
	int half = 3;

	// Serial clock rests low and the port deselected between frames.
	initial begin
		sclk = 1'b0;
		sdenb_n = 1'b1;
		sd = 1'b0;
	end

	// One frame: eight instruction bits, sixteen data bits, read bits taken before the falls of bits 7 to 22.
	task automatic xfer(input logic rd, input logic [6:0] a, input logic [15:0] d, output logic [15:0] q);
		logic [23:0] f;
		f = {rd, a, d};
		q = 16'h0000;
		@(posedge clk);
		sdenb_n <= 1'b0;
		for (int i = 0; i < 24; i++) begin
			sd <= (rd && i > 7) ? ~sd : f[23 - i];
			repeat (half) @(posedge clk);
			sclk <= 1'b1;
			repeat (half) @(posedge clk);
			if (i > 6 && i < 23) q = {q[14:0], rd_line};
			sclk <= 1'b0;
		end
		repeat (half) @(posedge clk);
		sdenb_n <= 1'b1;
		sd <= ~sd;
		@(posedge clk);
	endtask

endmodule

`default_nettype wire

// file: bench/dica_regs_test.sv
`default_nettype none
`define CHK(n, e, s) check_count++; if ((s) !== (e)) begin miscompares++; $display("[ERR] %s expected %h seen %h", n, e, s); end

module dica_regs_test
	import dica_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic CLK = 1'b0;
	logic NRST = 1'b0;
	logic INPUT_STROBE = 1'b0, SYNC_INPUT = 1'b0, CHECK_BIT_INPUT = 1'b0, TRANSMIT_ENABLE_PIN = 1'b0;
	logic DACCLK_LOST = 1'b0, DATACLK_LOST = 1'b0, PLL_UNLOCK = 1'b0;
	logic [15:0] BUS_AB = 16'h0000, BUS_CD = 16'h0000;
	logic [7:0] FIFO_WR_PTR = 8'h01, FIFO_RD_PTR = 8'h10, TEMP_CODE = 8'h3C;
	logic SDIO_OUT, SDIO_OE_N, SDO_OUT, SDO_OE_N, OUTPUT_OFF, MIXER_ON, MIXER_BOOST, OSC_ON;
	logic SERIAL_FOUR_WIRE, FIFO_SYNC, ALARM;
	logic [15:0] OUT_A, OUT_B, OUT_C, OUT_D;
	logic [4:0] OUT_FULLSCALE;
	wire logic SCLK, SDENB_N, host_d;
	logic four = 1'b0, odd = 1'b0, bad = 1'b0, run = 1'b0, res_v = 1'b0;
	logic [15:0] hab = 16'h0000, hcd = 16'h0000, res, e;
	logic [31:0] seed = 32'h2D4A033E;
	int miscompares = 0;
	int check_count = 0;
	string nq[$], n;
	logic [15:0] eq[$];
	logic [6:0] ra[5] = '{ADDR_INCHK, ADDR_PATH, ADDR_FSTX, ADDR_MASK, 7'h10};
	logic [15:0] re[5] = '{RST_INCHK, RST_PATH, RST_FSTX, RST_MASK, 16'h0000};
	logic [15:0] ik[4] = '{16'h040E, 16'h040E, 16'h040E, 16'h048E};
	logic [15:0] pk[4] = '{16'h7000, 16'h7002, 16'h7008, 16'h7000};
	logic [15:0] ae[8] = '{16'h0500, 16'h0300, 16'h2100, 16'h1000, 16'h0800, 16'h8000, 16'h0020, 16'h0000};

	// The read pin level follows whichever party drives it; a free pin toggles.
	wire logic SDIO_IN = SDIO_OE_N ? host_d : SDIO_OUT;
	wire logic rd_line = four ? (SDO_OE_N ? ~host_d : SDO_OUT) : SDIO_IN;

	dica_regs dica_regs_inst (.*);

	dica_host dica_host_inst (.clk(CLK), .rd_line(rd_line), .sclk(SCLK), .sdenb_n(SDENB_N), .sd(host_d));

	// ****************************************
	// Clock, source and result monitor.
	// ****************************************
	always #4 CLK = ~CLK;

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction

	// Random words carry even parity per bus so any parity mode sees a good word.
	always @(posedge CLK) begin
		seed = xs(seed);
		BUS_AB <= run ? {seed[15:1], ^seed[15:1]} : hab;
		BUS_CD <= run ? {seed[31:17], ^seed[31:17]} : hcd;
		CHECK_BIT_INPUT <= (run ? 1'b0 : ^{hab, hcd}) ^ odd ^ bad;
		SYNC_INPUT <= seed[7];
		INPUT_STROBE <= seed[9];
	end

	// Each posted result is compared with the oldest expectation.
	always @(posedge CLK) begin
		if (res_v === 1'b1) begin
			n = nq.pop_front();
			e = eq.pop_front();
			`CHK(n, e, res)
		end
	end

	task automatic post(input string nm, input logic [15:0] ex, input logic [15:0] s);
		nq.push_back(nm);
		eq.push_back(ex);
		@(posedge CLK);
		res <= s;
		res_v <= 1'b1;
		@(posedge CLK);
		res_v <= 1'b0;
	endtask

	task automatic tick(input int c);
		repeat (c) @(posedge CLK);
	endtask

	task automatic wr(input logic [6:0] a, input logic [15:0] d);
		logic [15:0] q;
		dica_host_inst.xfer(1'b0, a, d, q);
	endtask

	task automatic rd(input string nm, input logic [6:0] a, input logic [15:0] ex);
		logic [15:0] q;
		dica_host_inst.xfer(1'b1, a, 16'h0000, q);
		post(nm, ex, q);
	endtask

	task automatic final_report;
		if (miscompares == 0 && check_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	// A hung run is cut short and reported as failed.
	initial begin
		repeat (60000) @(posedge CLK);
		miscompares++;
		final_report();
	end

	// ****************************************
	// Main sequence.
	// ****************************************
	initial begin
		logic [15:0] v, q;
		repeat (16) @(posedge CLK);
		NRST <= 1'b1;
		tick(2);
		foreach (ra[i]) rd("reset", ra[i], re[i]);
		post("fs", 16'h0010, {11'h000, OUT_FULLSCALE});
		wr(ADDR_TEMP, 16'hFFFF);
		rd("temp", ADDR_TEMP, {TEMP_CODE, 8'h00});
		wr(ADDR_PATH, 16'h70F0);
		four = 1'b1;
		post("ctl", 16'h000F, {12'h000, MIXER_ON, MIXER_BOOST, OSC_ON, SERIAL_FOUR_WIRE});
		dica_host_inst.half = 6;
		rd("path4", ADDR_PATH, 16'h70F0);
		dica_host_inst.half = 3;
		wr(ADDR_PATH, RST_PATH);
		four = 1'b0;
		wr(ADDR_FSTX, 16'h5001);
		post("fs6", 16'h0006, {11'h000, OUT_FULLSCALE});
		// Held words through each format and reversal setting, then with the channel A invert.
		for (int k = 0; k < 4; k++) begin
			wr(ADDR_INCHK, ik[k]);
			wr(ADDR_PATH, pk[k]);
			v = seed[31:16];
			hab = v;
			hcd = ~v;
			tick(6);
			case (k)
				0: q = v;
				1: q = v ^ 16'h8000;
				2: q = {<<{v}};
				default: q = ~v;
			endcase
			post("out_a", q, OUT_A);
			post("out_b", k == 3 ? v : q, OUT_B);
			post("out_c", k == 3 ? q : ~q, OUT_C);
			post("out_d", k == 3 ? q : ~q, OUT_D);
		end
		wr(ADDR_INCHK, 16'h040E);
		wr(ADDR_FSTX, 16'hF000);
		post("txoff", 16'h8000, OUT_A);
		TRANSMIT_ENABLE_PIN <= 1'b1;
		tick(4);
		post("txpin", v, OUT_A);
		// Rotated pins: the check bit pin now feeds the FIFO sync.
		wr(ADDR_INCHK, 16'h050E);
		hcd = 16'h0000;
		for (int k = 0; k < 2; k++) begin
			hab = 16'(1 - k);
			tick(4);
			post("sync", 16'(1 - k), {15'h0000, FIFO_SYNC});
		end
		// Pattern checker with all patterns equal, then one failing bit.
		wr(ADDR_INCHK, 16'h840E);
		post("iotest", 16'h8000, OUT_A);
		for (int k = 0; k < 8; k++) wr(ADDR_PAT0 + 7'(k), 16'h3C3C);
		hab = 16'h3C3C;
		hcd = 16'h3C3C;
		tick(4);
		wr(ADDR_RESULTS, 16'h0000);
		wr(ADDR_ALARM, 16'h0000);
		rd("nofail", ADDR_RESULTS, 16'h0000);
		hab = 16'h3D3C;
		tick(8);
		rd("fail", ADDR_RESULTS, 16'h0100);
		rd("patalm", ADDR_ALARM, 16'h0080);
		hab = 16'h3C3C;
		tick(4);
		wr(ADDR_RESULTS, 16'h0000);
		rd("wclr", ADDR_RESULTS, 16'h0000);
		// Parity sense, single and dual mode, good and bad check bit.
		run = 1'b1;
		for (int k = 0; k < 8; k++) begin
			odd = k[0];
			bad = k[1];
			wr(ADDR_INCHK, 16'h040E | (16'(k[0]) << 11) | (16'(k[2]) << 9));
			wr(ADDR_ALARM, 16'h0000);
			tick(4);
			rd("parity", ADDR_ALARM, !k[1] ? 16'h0000 : k[2] ? 16'h001E : 16'h0018);
		end
		odd = 1'b0;
		bad = 1'b0;
		wr(ADDR_INCHK, 16'h040E);
		wr(ADDR_MASK, 16'h0000);
		// Each alarm cause in turn, then collision with its enable off.
		for (int k = 0; k < 8; k++) begin
			wr(ADDR_ALARM, 16'h0000);
			tick(4);
			post("clr", 16'h0000, {14'h0000, ALARM, OUTPUT_OFF});
			case (k)
				0: DACCLK_LOST <= 1'b1;
				1: DATACLK_LOST <= 1'b1;
				2: FIFO_RD_PTR <= 8'h01;
				3: FIFO_RD_PTR <= 8'h02;
				4: FIFO_RD_PTR <= 8'h04;
				5: FIFO_WR_PTR <= 8'h00;
				6: PLL_UNLOCK <= 1'b1;
				default: begin
					wr(ADDR_INCHK, 16'h0400);
					FIFO_RD_PTR <= 8'h01;
				end
			endcase
			tick(2);
			{DACCLK_LOST, DATACLK_LOST, PLL_UNLOCK} <= 3'b000;
			FIFO_WR_PTR <= 8'h01;
			FIFO_RD_PTR <= 8'h10;
			tick(4);
			rd("event", ADDR_ALARM, ae[k]);
			post("pins", {14'h0000, k < 7, k < 3}, {14'h0000, ALARM, OUTPUT_OFF});
		end
		// A pulse alarm stays without auto-clear and is wiped by a good run with it.
		wr(ADDR_MASK, 16'hFFFF);
		for (int k = 0; k < 2; k++) begin
			wr(ADDR_INCHK, k ? 16'h140E : 16'h040E);
			wr(ADDR_ALARM, 16'h0000);
			PLL_UNLOCK <= 1'b1;
			tick(2);
			PLL_UNLOCK <= 1'b0;
			tick(70);
			rd("autoclr", ADDR_ALARM, k ? 16'h0000 : 16'h0020);
		end
		final_report();
	end

endmodule

`default_nettype wire
